// >>> src/fthd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fthd_decode
  #(
  parameter logic [7:0] HALT_OPCODE = fthd_pkg::OP_HALT_DEFAULT
  )
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // instruction in execute stage
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic supervisor_mode,
  // operands read from the register file
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  // following instruction and memory side
  input wire logic next_instr_valid,
  input wire logic next_instr_exception,
  input wire logic data_access_busy,
  // trap request, one cycle
  output logic trap_req,
  output fthd_pkg::fthd_trap_t trap_kind,
  // indirect pointers
  output logic [7:0] indirect_ptr_first_src,
  output logic [7:0] indirect_ptr_second_src,
  output logic [7:0] indirect_ptr_dest,
  // architectural compare result for a handler
  output logic [31:0] compare_result,
  // run state
  output logic halt_mode,
  output logic halt_pending
);
  import fthd_pkg::*;

  fthd_state_t state;
  fthd_state_t next_state;
  fthd_trap_t next_trap_kind;

  wire [7:0] opcode = instr_word[OP_MSB:OP_LSB];
  wire [7:0] dest_field = instr_word[DEST_LSB +: FIELD_W];
  wire [7:0] first_source_field = instr_word[FIRST_LSB +: FIELD_W];
  wire [7:0] second_source_field =
    instr_word[SECOND_LSB +: FIELD_W];

  wire running = (state == ST_RUN);
  wire take = instr_valid && running;
  wire is_gt = take && (opcode == OP_FLOAT_GREATER_COMPARE);
  wire is_lt = take && (opcode == OP_FLOAT_LESS_COMPARE);
  wire is_mul = take && (opcode == OP_FLOAT_MULTIPLY);
  wire is_sub = take && (opcode == OP_FLOAT_SUBTRACT);
  wire is_halt = take && (opcode == HALT_OPCODE);
  wire float_trap = is_gt || is_lt || is_mul || is_sub;
  wire halt_denied = is_halt && !supervisor_mode;
  wire halt_ok = is_halt && supervisor_mode;
  // exception of the following instruction goes first
  wire follow_exc = (state == ST_DRAIN) && next_instr_valid
    && next_instr_exception;

  wire a_gt_b;
  wire b_gt_a;

  fthd_float_cmp u_cmp_ab
  (
    .a(first_operand),
    .b(second_operand),
    .a_gt_b(a_gt_b)
  );

  fthd_float_cmp u_cmp_ba
  (
    .a(second_operand),
    .b(first_operand),
    .a_gt_b(b_gt_a)
  );

  wire cmp_true = is_gt ? a_gt_b : b_gt_a;
  wire [31:0] next_compare = cmp_true ? BOOL_TRUE : BOOL_FALSE;

  always_comb
  begin
    next_trap_kind = TRAP_NONE;
    if (is_gt)
    begin
      next_trap_kind = TRAP_FLOAT_GREATER;
    end
    else if (is_lt)
    begin
      next_trap_kind = TRAP_FLOAT_LESS;
    end
    else if (is_mul)
    begin
      next_trap_kind = TRAP_FLOAT_MULTIPLY;
    end
    else if (is_sub)
    begin
      next_trap_kind = TRAP_FLOAT_SUBTRACT;
    end
    else if (halt_denied)
    begin
      next_trap_kind = TRAP_PROTECTION;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (halt_ok)
        begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        // wait for data accesses and any trap of the follower
        if (!follow_exc && !data_access_busy)
        begin
          next_state = ST_HALTED;
        end
      end
      ST_HALTED:
      begin
        next_state = ST_HALTED;
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= ST_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      trap_req <= 1'b0;
      trap_kind <= TRAP_NONE;
    end
    else
    begin
      trap_req <= float_trap || halt_denied;
      trap_kind <= next_trap_kind;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      indirect_ptr_first_src <= PTR_RESET;
      indirect_ptr_second_src <= PTR_RESET;
      indirect_ptr_dest <= PTR_RESET;
      compare_result <= BOOL_FALSE;
    end
    else if (float_trap)
    begin
      indirect_ptr_first_src <= first_source_field;
      indirect_ptr_second_src <= second_source_field;
      indirect_ptr_dest <= dest_field;
      compare_result <= next_compare;
    end
  end

  assign halt_mode = (state == ST_HALTED);
  assign halt_pending = (state == ST_DRAIN);
endmodule
`default_nettype wire

// >>> src/fthd_pkg.sv
// Overview of operation
// - Opcode EC, greater-than float compare, traps instead of computing.
// - Opcode EE, less-than float compare, traps instead of a result.
// - Opcode F4, float multiply, traps instead of a product.
// - Opcode F2, float subtract, traps instead of a difference.
// - A float trap loads the pointers with first, second and dest fields.
// - Fields: opcode 31-24, dest 23-16, first 15-8, second 7-0.
// - Greater-than TRUE if first float exceeds second; less-than mirrors.
// - An executed halt enters the drain state (halt_pending) on the following cycle and halt mode at least one cycle after.
// - Halt first lets every external data access in progress complete.
// - Supervisor-only halt; user mode takes a protection trap instead.
// - A trap of the instruction after halt is taken before halting.
package fthd_pkg;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 24;
  localparam int DEST_LSB = 16;
  localparam int FIRST_LSB = 8;
  localparam int SECOND_LSB = 0;
  localparam int FIELD_W = 8;
  localparam logic [7:0] OP_FLOAT_GREATER_COMPARE = 8'hEC;
  localparam logic [7:0] OP_FLOAT_LESS_COMPARE = 8'hEE;
  localparam logic [7:0] OP_FLOAT_MULTIPLY = 8'hF4;
  localparam logic [7:0] OP_FLOAT_SUBTRACT = 8'hF2;
  localparam logic [7:0] OP_HALT_DEFAULT = 8'h89;
  localparam logic [31:0] BOOL_TRUE = 32'h80000000;
  localparam logic [31:0] BOOL_FALSE = 32'h00000000;
  localparam logic [7:0] PTR_RESET = 8'h00;

  typedef enum logic [3:0] {
    TRAP_NONE = 4'h0,
    TRAP_FLOAT_GREATER = 4'h1,
    TRAP_FLOAT_LESS = 4'h2,
    TRAP_FLOAT_MULTIPLY = 4'h3,
    TRAP_FLOAT_SUBTRACT = 4'h4,
    TRAP_PROTECTION = 4'h5
  } fthd_trap_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_DRAIN = 3'b010,
    ST_HALTED = 3'b100
  } fthd_state_t;
endpackage

// >>> src/fthd_float_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// single-precision signed order, zeros equal, nan never ordered
module fthd_float_cmp
(
  // operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // result
  output logic a_gt_b
);
  wire a_nan = (a[30:23] == 8'hFF) && (a[22:0] != 23'h000000);
  wire b_nan = (b[30:23] == 8'hFF) && (b[22:0] != 23'h000000);
  wire both_zero = (a[30:0] == 31'h00000000) && (b[30:0] == 31'h00000000);
  wire mag_gt = a[30:0] > b[30:0];
  wire mag_lt = a[30:0] < b[30:0];
  wire ord_gt = (a[31] != b[31]) ? b[31] : (a[31] ? mag_lt : mag_gt);
  assign a_gt_b = !a_nan && !b_nan && !both_zero && ord_gt;
endmodule
`default_nettype wire

// >>> testbench/fthd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fthd_checker
  import fthd_pkg::*;
  #(parameter logic [7:0] HALT_OPCODE = 8'h89)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // inputs
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic supervisor_mode,
  input wire logic next_instr_valid,
  input wire logic next_instr_exception,
  input wire logic data_access_busy,
  // outputs
  input wire logic trap_req,
  input wire fthd_pkg::fthd_trap_t trap_kind,
  input wire logic [7:0] indirect_ptr_first_src,
  input wire logic [7:0] indirect_ptr_second_src,
  input wire logic [7:0] indirect_ptr_dest,
  input wire logic halt_mode,
  input wire logic halt_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire tk = instr_valid && !halt_pending && !halt_mode;
  wire [7:0] op = instr_word[31:24];
  wire exc = next_instr_valid && next_instr_exception;
  wire fop = tk && (op == OP_FLOAT_GREATER_COMPARE
    || op == OP_FLOAT_LESS_COMPARE || op == OP_FLOAT_MULTIPLY
    || op == OP_FLOAT_SUBTRACT);
  AST_GT:
    assert property (tk && op == 8'hEC |=> trap_kind == TRAP_FLOAT_GREATER)
    else $error("gt trap missing");
  AST_LT:
    assert property (tk && op == 8'hEE |-> ##1 trap_kind == TRAP_FLOAT_LESS)
    else $error("lt trap missing");
  AST_MUL:
    assert property (tk && op == 8'hF4 |=> trap_req && trap_kind == 4'h3)
    else $error("mul trap missing");
  AST_SUB:
    assert property (tk && op == 8'hF2 |=> trap_req && trap_kind == 4'h4)
    else $error("sub trap missing");
  AST_PTR:
    assert property (fop |=> indirect_ptr_dest == $past(instr_word[23:16])
      && indirect_ptr_first_src == $past(instr_word[15:8])
      && indirect_ptr_second_src == $past(instr_word[7:0]))
    else $error("pointer wrong");
  AST_IDLE:
    assert property (instr_valid && (halt_pending || halt_mode) |=> !trap_req)
    else $error("instruction taken while halting");
  AST_USER:
    assert property (tk && op == HALT_OPCODE && !supervisor_mode |=>
      trap_kind == TRAP_PROTECTION && !halt_pending)
    else $error("user halt wrong");
  AST_HOLD:
    assert property (halt_pending && (data_access_busy || exc) |=> !halt_mode)
    else $error("halt too early");
  AST_GO:
    assert property (halt_pending && !data_access_busy && !exc |=> halt_mode)
    else $error("halt late");
  cover property (trap_req);
  cover property (halt_pending && data_access_busy);
  cover property ($rose(halt_mode));
  cover property (halt_pending && exc);
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fthd_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, iv = 1'b0, sup = 1'b1;
  logic nv = 1'b0, ne = 1'b0, bz = 1'b0;
  logic [31:0] iw = 32'h0, fa = 32'h3F800000, fb = 32'h0, cr;
  logic tr, hm, hp;
  logic [7:0] p1, p2, pd;
  fthd_trap_t tk;
  int n_fail = 0, comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  fthd_decode fthd_decode_i (.clk_sys, .rst, .instr_valid(iv),
    .instr_word(iw), .supervisor_mode(sup), .first_operand(fa),
    .second_operand(fb), .next_instr_valid(nv), .next_instr_exception(ne),
    .data_access_busy(bz), .trap_req(tr), .trap_kind(tk),
    .indirect_ptr_first_src(p1), .indirect_ptr_second_src(p2),
    .indirect_ptr_dest(pd), .compare_result(cr), .halt_mode(hm),
    .halt_pending(hp));
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic issue(logic [31:0] w);
    @(negedge clk_sys);
    iv = 1;
    iw = w;
    @(negedge clk_sys);
    iv = 0;
  endtask
  task automatic conclude;
    $display("%0d checks, %0d bad", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_float;
    logic [7:0] ops [4] = '{OP_FLOAT_GREATER_COMPARE, OP_FLOAT_LESS_COMPARE,
      OP_FLOAT_MULTIPLY, OP_FLOAT_SUBTRACT};
    fthd_trap_t kinds [4] = '{TRAP_FLOAT_GREATER, TRAP_FLOAT_LESS,
      TRAP_FLOAT_MULTIPLY, TRAP_FLOAT_SUBTRACT};
    logic [4:0] exp_trap;
    logic [23:0] exp_ptr;
    for (int i = 0; i < 4; i++)
    begin
      issue({ops[i], 8'(i + 8'hD0), 8'(i + 8'h10), 8'(i + 8'h20)});
      exp_trap = {1'b1, kinds[i]};
      exp_ptr = {8'(i + 8'h10), 8'(i + 8'h20), 8'(i + 8'hD0)};
      chk("trap", {tr, tk}, exp_trap);
      chk("ptr", {p1, p2, pd}, exp_ptr);
      if (i < 2)
        chk("cmp", cr, i == 0 ? BOOL_TRUE : BOOL_FALSE);
    end
  endtask
  task automatic t_user;
    sup = 0;
    issue({OP_HALT_DEFAULT, 24'h0});
    chk("prot", {tr, tk}, {1'b1, TRAP_PROTECTION});
    @(negedge clk_sys);
    sup = 1;
    chk("run", {hp, hm}, 2'b00);
    chk("pulse", tr, 1'b0);
  endtask
  task automatic t_halt;
    nv = 1;
    ne = 1;
    issue({OP_HALT_DEFAULT, 24'h0});
    chk("pend", hp, 1'b1);
    repeat (3) @(negedge clk_sys);
    chk("exc", hm, 1'b0);
    ne = 0;
    bz = 1;
    repeat (3) @(negedge clk_sys);
    chk("busy", hm, 1'b0);
    bz = 0;
    @(negedge clk_sys);
    chk("halt", {hm, hp}, 2'b10);
    issue({8'hEC, 24'h010203});
    chk("idle", tr, 1'b0);
  endtask
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst = 0;
    t_float;
    t_user;
    t_halt;
    conclude;
  end
  initial
  begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
bind fthd_decode fthd_checker #(.HALT_OPCODE(HALT_OPCODE)) fthd_checker_i (
  .clk_sys, .rst, .instr_valid, .instr_word, .supervisor_mode,
  .next_instr_valid, .next_instr_exception, .data_access_busy, .trap_req,
  .trap_kind, .indirect_ptr_first_src, .indirect_ptr_second_src,
  .indirect_ptr_dest, .halt_mode, .halt_pending);
`default_nettype wire
